// ==== bcr_pkg.sv ====
// Package with offsets, capability codes, next pointers and reset values of the bridge capability registers.
package bcr_pkg;

  localparam logic [7:0]  BCR_OFF_TIMEOUT   = 8'h80;
  localparam logic [7:0]  BCR_OFF_SLOT      = 8'hb0;
  localparam logic [7:0]  BCR_OFF_PWR_CAP   = 8'hdc;
  localparam logic [7:0]  BCR_OFF_PWR_CTL   = 8'he0;
  localparam logic [7:0]  BCR_OFF_LAST      = 8'he4;

  localparam logic [15:0] BCR_TIMEOUT_RST   = 16'h8000;
  localparam logic [7:0]  BCR_SLOT_CAP_CODE = 8'h04;
  localparam logic [7:0]  BCR_SLOT_NEXT_HS  = 8'hc0;
  localparam logic [7:0]  BCR_SLOT_NEXT_END = 8'h00;
  localparam logic [4:0]  BCR_SLOT_NUM_RST  = 5'h00;
  localparam logic [7:0]  BCR_CHASSIS_RST   = 8'h00;
  localparam logic [7:0]  POWER_MGMT_CAP_CODE = 8'h01;
  localparam logic [7:0]  BCR_PWR_NEXT      = 8'h0b;
  localparam logic [2:0]  BCR_PWR_REV       = 3'h1;
  localparam logic [7:0]  HOT_SWAP_CAP_CODE = 8'h06;
  localparam logic [7:0]  BCR_LAST_NEXT     = 8'h00;

  localparam logic [1:0]  BCR_PS_D0         = 2'h0;
  localparam logic [1:0]  BCR_PS_D1         = 2'h1;
  localparam logic [1:0]  BCR_PS_D2         = 2'h2;
  localparam logic [1:0]  BCR_PS_D3         = 2'h3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic        wr;
    logic        rd;
  } bcr_req_t;

endpackage : bcr_pkg

// ==== bcr_regs.sv ====
// Capability register group of the two-port bridge.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module bcr_regs
  import bcr_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire bcr_req_t    req_i,
  input  wire logic        hot_swap_enable_input_i,
  output logic [31:0]      rdata_o,
  output logic [15:0]      sec_timeout_o,
  output logic [1:0]       power_state_o,
  output logic             chip_reset_o
);

  logic [15:0] timeout_q;
  logic [15:0] timeout_d;
  logic [4:0]  slot_q;
  logic [4:0]  slot_d;
  logic        first_q;
  logic        first_d;
  logic [7:0]  chassis_q;
  logic [7:0]  chassis_d;
  logic [1:0]  pstate_q;
  logic [1:0]  pstate_d;
  logic        chip_rst_q;
  logic        chip_rst_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        hs_meta_q;
  logic        hs_sync_q;
  logic        wr_tmo;
  logic        wr_slot;
  logic        wr_pwr;
  logic        rd_tmo;
  logic        rd_slot;
  logic        rd_pcap;
  logic        rd_pctl;
  logic        rd_last;
  logic        rd_unmapped;
  logic [7:0]  slot_next;

  // Writes decode on an exact byte address, so a stray address is dropped silently.
  assign wr_tmo  = req_i.wr && (req_i.addr == BCR_OFF_TIMEOUT);
  assign wr_slot = req_i.wr && (req_i.addr == BCR_OFF_SLOT);
  assign wr_pwr  = req_i.wr && (req_i.addr == BCR_OFF_PWR_CTL) && req_i.be[0];

  // Read decodes only feed the checks below; the read mux decodes on its own.
  assign rd_tmo      = req_i.rd && (req_i.addr == BCR_OFF_TIMEOUT);
  assign rd_slot     = req_i.rd && (req_i.addr == BCR_OFF_SLOT);
  assign rd_pcap     = req_i.rd && (req_i.addr == BCR_OFF_PWR_CAP);
  assign rd_pctl     = req_i.rd && (req_i.addr == BCR_OFF_PWR_CTL);
  assign rd_last     = req_i.rd && (req_i.addr == BCR_OFF_LAST);
  assign rd_unmapped = req_i.rd && !(rd_tmo || rd_slot || rd_pcap || rd_pctl || rd_last);

  assign slot_next = hs_sync_q ? BCR_SLOT_NEXT_HS : BCR_SLOT_NEXT_END;

  always_comb begin
    timeout_d  = timeout_q;
    slot_d     = slot_q;
    first_d    = first_q;
    chassis_d  = chassis_q;
    pstate_d   = pstate_q;
    chip_rst_d = 1'b0;
    if (wr_tmo && req_i.be[2]) begin
      timeout_d[7:0] = req_i.wdata[23:16];
    end
    if (wr_tmo && req_i.be[3]) begin
      timeout_d[15:8] = req_i.wdata[31:24];
    end
    if (wr_slot && req_i.be[2]) begin
      slot_d  = req_i.wdata[20:16];
      first_d = req_i.wdata[21];
    end
    if (wr_slot && req_i.be[3]) begin
      chassis_d = req_i.wdata[31:24];
    end
    if (wr_pwr && (req_i.wdata[1:0] == BCR_PS_D0 || req_i.wdata[1:0] == BCR_PS_D3)) begin
      pstate_d = req_i.wdata[1:0];
    end
    if (wr_pwr && pstate_q == BCR_PS_D3 && req_i.wdata[1:0] == BCR_PS_D0) begin
      chip_rst_d = 1'b1;
    end
  end

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (req_i.rd) begin
      case (req_i.addr)
        BCR_OFF_TIMEOUT: rdata_d = {timeout_q, 16'h0000};
        BCR_OFF_SLOT:    rdata_d = {chassis_q, 2'h0, first_q, slot_q, slot_next,
                                    BCR_SLOT_CAP_CODE};
        BCR_OFF_PWR_CAP: rdata_d = {13'h0000, BCR_PWR_REV, BCR_PWR_NEXT,
                                    POWER_MGMT_CAP_CODE};
        BCR_OFF_PWR_CTL: rdata_d = {30'h0000_0000, pstate_q};
        BCR_OFF_LAST:    rdata_d = {16'h0000, BCR_LAST_NEXT, HOT_SWAP_CAP_CODE};
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // The enable pin is a strap from outside, so it is synchronised first.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hs_meta_q  <= 1'b0;
      hs_sync_q  <= 1'b0;
      timeout_q  <= BCR_TIMEOUT_RST;
      slot_q     <= BCR_SLOT_NUM_RST;
      first_q    <= 1'b0;
      chassis_q  <= BCR_CHASSIS_RST;
      pstate_q   <= BCR_PS_D0;
      chip_rst_q <= 1'b0;
      rdata_q    <= 32'h0000_0000;
    end else begin
      hs_meta_q  <= hot_swap_enable_input_i;
      hs_sync_q  <= hs_meta_q;
      timeout_q  <= timeout_d;
      slot_q     <= slot_d;
      first_q    <= first_d;
      chassis_q  <= chassis_d;
      pstate_q   <= pstate_d;
      chip_rst_q <= chip_rst_d;
      rdata_q    <= rdata_d;
    end
  end

  assign rdata_o       = rdata_q;
  assign sec_timeout_o = timeout_q;
  assign power_state_o = pstate_q;
  assign chip_reset_o  = chip_rst_q;

  // Chip reset pulse follows a wake write by one cycle.
  // wake pulses reset
  chk_wake_reset_pulse: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_pwr && pstate_q == BCR_PS_D3 && req_i.wdata[1:0] == BCR_PS_D0) |=> chip_reset_o)
    else $error("wake write did not reset chip");

  chk_no_spurious_reset: assert property (@(posedge clock_i) disable iff (!rstn_i)
    chip_reset_o |-> $past(pstate_q) == BCR_PS_D3 && pstate_q == BCR_PS_D0)
    else $error("chip reset without wake");

  chk_pstate_legal: assert property (@(posedge clock_i) disable iff (!rstn_i)
    power_state_o == BCR_PS_D0 || power_state_o == BCR_PS_D3)
    else $error("illegal power state held");

  chk_pstate_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !wr_pwr |=> $stable(power_state_o))
    else $error("power state changed without write");

  chk_timeout_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !wr_tmo |=> $stable(sec_timeout_o))
    else $error("timeout changed without write");

  chk_timeout_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_tmo && req_i.be[3:2] == 2'h3) |=> sec_timeout_o == $past(req_i.wdata[31:16]))
    else $error("timeout write lost");

  chk_pwr_cap_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (req_i.rd && req_i.addr == BCR_OFF_PWR_CAP) |=> rdata_o == 32'h0001_0b01)
    else $error("power capability word wrong");

  chk_slot_next_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (req_i.rd && req_i.addr == BCR_OFF_SLOT) |=>
    rdata_o[15:8] == ($past(hs_sync_q) ? BCR_SLOT_NEXT_HS : BCR_SLOT_NEXT_END))
    else $error("slot next pointer wrong");

  chk_last_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (req_i.rd && req_i.addr == BCR_OFF_LAST) |=> rdata_o == 32'h0000_0006)
    else $error("last header wrong");

  chk_ctl_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (req_i.rd && req_i.addr == BCR_OFF_PWR_CTL) |=> rdata_o[31:2] == 30'h0)
    else $error("power control upper bits nonzero");

  chk_tmo_low_lane: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_tmo && req_i.be[2])
    |=> sec_timeout_o[7:0] == $past(req_i.wdata[23:16]))
    else $error("timeout low byte lost");

  chk_tmo_high_lane: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_tmo && req_i.be[3])
    |=> sec_timeout_o[15:8] == $past(req_i.wdata[31:24]))
    else $error("timeout high byte lost");

  chk_tmo_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_tmo
    |=> rdata_o == {$past(sec_timeout_o), 16'h0000})
    else $error("timeout read wrong");

  chk_tmo_low_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_tmo && !req_i.be[2])
    |=> sec_timeout_o[7:0] == $past(sec_timeout_o[7:0]))
    else $error("timeout low byte written without enable");

  chk_tmo_high_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_tmo && !req_i.be[3])
    |=> sec_timeout_o[15:8] == $past(sec_timeout_o[15:8]))
    else $error("timeout high byte written without enable");

  chk_slot_code_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_slot
    |=> rdata_o[7:0] == BCR_SLOT_CAP_CODE)
    else $error("slot capability code wrong");

  chk_slot_next_end: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rd_slot && !hs_sync_q)
    |=> rdata_o[15:8] == BCR_SLOT_NEXT_END)
    else $error("slot pointer not end");

  chk_slot_next_hs: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (rd_slot && hs_sync_q)
    |=> rdata_o[15:8] == BCR_SLOT_NEXT_HS)
    else $error("slot pointer not hot swap");

  chk_slot_num_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_slot && req_i.be[2])
    |=> slot_q == $past(req_i.wdata[20:16]))
    else $error("slot number write lost");

  chk_first_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_slot && req_i.be[2])
    |=> first_q == $past(req_i.wdata[21]))
    else $error("first in chassis write lost");

  chk_chassis_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_slot && req_i.be[3])
    |=> chassis_q == $past(req_i.wdata[31:24]))
    else $error("chassis number write lost");

  chk_slot_rsvd_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_slot
    |=> rdata_o[23:22] == 2'h0)
    else $error("slot reserved bits nonzero");

  chk_slot_fields_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_slot
    |=> rdata_o[31:16] == {$past(chassis_q), 2'h0, $past(first_q), $past(slot_q)})
    else $error("slot fields read wrong");

  chk_slot_lane_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !(wr_slot && req_i.be[2])
    |=> $stable(slot_q) && $stable(first_q))
    else $error("slot lane changed without enable");

  chk_chassis_keep: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !(wr_slot && req_i.be[3])
    |=> $stable(chassis_q))
    else $error("chassis changed without enable");

  chk_pwr_code_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_pcap
    |=> rdata_o[7:0] == POWER_MGMT_CAP_CODE)
    else $error("power capability code wrong");

  chk_pwr_next_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_pcap
    |=> rdata_o[15:8] == BCR_PWR_NEXT)
    else $error("power next pointer wrong");

  chk_pwr_rev_field: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_pcap
    |=> rdata_o[18:16] == BCR_PWR_REV)
    else $error("power revision wrong");

  chk_pwr_cap_zero: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_pcap
    |=> rdata_o[31:19] == 13'h0000)
    else $error("power capability bits nonzero");

  chk_pstate_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_pwr && (req_i.wdata[1:0] == BCR_PS_D0 || req_i.wdata[1:0] == BCR_PS_D3))
    |=> power_state_o == $past(req_i.wdata[1:0]))
    else $error("power state write lost");

  chk_pstate_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_pctl
    |=> rdata_o[1:0] == $past(power_state_o))
    else $error("power state read wrong");

  chk_pstate_drop: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (wr_pwr && (req_i.wdata[1:0] == BCR_PS_D1 || req_i.wdata[1:0] == BCR_PS_D2))
    |=> $stable(power_state_o))
    else $error("unimplemented power state taken");

  chk_pwr_lane_gate: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (req_i.wr && req_i.addr == BCR_OFF_PWR_CTL && !req_i.be[0])
    |=> $stable(power_state_o))
    else $error("power state written without enable");

  chk_reset_single: assert property (@(posedge clock_i) disable iff (!rstn_i)
    chip_reset_o
    |=> !chip_reset_o)
    else $error("chip reset longer than one cycle");

  chk_no_reset_awake: assert property (@(posedge clock_i) disable iff (!rstn_i)
    !(wr_pwr && pstate_q == BCR_PS_D3)
    |=> !chip_reset_o)
    else $error("chip reset without sleep state");

  chk_last_code_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_last
    |=> rdata_o[7:0] == HOT_SWAP_CAP_CODE)
    else $error("last capability code wrong");

  chk_last_next_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_last
    |=> rdata_o[15:8] == BCR_LAST_NEXT)
    else $error("last next pointer nonzero");

  chk_unmapped_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
    rd_unmapped
    |=> rdata_o == 32'h0000_0000)
    else $error("unmapped read nonzero");

  // Main scenarios: wake, sleep, dropped code, slot and timeout writes.
  cov_wake: cover property (@(posedge clock_i) disable iff (!rstn_i) chip_reset_o);
  cov_sleep: cover property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(power_state_o == BCR_PS_D3));
  cov_bad_code: cover property (@(posedge clock_i) disable iff (!rstn_i)
    wr_pwr && req_i.wdata[1:0] == BCR_PS_D1);
  cov_slot_write: cover property (@(posedge clock_i) disable iff (!rstn_i) wr_slot);
  cov_tmo_write: cover property (@(posedge clock_i) disable iff (!rstn_i) wr_tmo);

endmodule : bcr_regs

// ==== bcr_regs_test.sv ====
// Self-checking bench for the bridge capability register group.
`timescale 1ns/1ps
module bcr_regs_test;
  import bcr_pkg::*;
  logic        clock_i;
  logic        rstn_i;
  bcr_req_t    req_i;
  logic        hs_in;
  logic [31:0] rdata;
  logic [15:0] tmo;
  logic [1:0]  ps;
  logic        crst;
  int          bad_count = 0;
  int          cmp_count = 0;

  bcr_regs i_dut (
    .clock_i                 (clock_i),
    .rstn_i                  (rstn_i),
    .req_i                   (req_i),
    .hot_swap_enable_input_i (hs_in),
    .rdata_o                 (rdata),
    .sec_timeout_o           (tmo),
    .power_state_o           (ps),
    .chip_reset_o            (crst)
  );

  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Strobes drop on the next edge, so each access leaves an idle cycle after it.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] b);
    @(posedge clock_i);
    req_i <= '{addr: a, wdata: d, be: b, wr: 1'b1, rd: 1'b0};
    @(posedge clock_i);
    req_i.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
    @(posedge clock_i);
    req_i <= '{addr: a, wdata: 32'h0, be: 4'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock_i);
    req_i.rd <= 1'b0;
    #1;
    chk(n, rdata, e);
  endtask : rd

  task automatic t_reset;
    chk("timeout out", {16'h0, tmo}, 32'h8000);
    rd(BCR_OFF_TIMEOUT, 32'h8000_0000, "timeout");
    rd(BCR_OFF_SLOT, 32'h0000_0004, "slot word");
    rd(BCR_OFF_PWR_CAP, 32'h0001_0b01, "power cap");
    rd(BCR_OFF_PWR_CTL, 32'h0, "power ctl");
    rd(BCR_OFF_LAST, 32'h0000_0006, "last cap");
    rd(8'h84, 32'h0, "unmapped");
    $display("test reset values done");
  endtask : t_reset

  task automatic t_fields;
    @(posedge clock_i);
    hs_in <= 1'b1;
    repeat (3) @(posedge clock_i);
    wr(BCR_OFF_TIMEOUT, 32'hffff_ffff, 4'hf);
    rd(BCR_OFF_TIMEOUT, 32'hffff_0000, "timeout all");
    wr(BCR_OFF_TIMEOUT, 32'h0012_0000, 4'h4);
    chk("timeout lane", {16'h0, tmo}, 32'hff12);
    wr(BCR_OFF_SLOT, 32'hffff_ffff, 4'hf);
    rd(BCR_OFF_SLOT, 32'hff3f_c004, "slot all");
    wr(BCR_OFF_SLOT, 32'h0, 4'h8);
    rd(BCR_OFF_SLOT, 32'h003f_c004, "chassis lane");
    wr(BCR_OFF_PWR_CAP, 32'hffff_ffff, 4'hf);
    rd(BCR_OFF_PWR_CAP, 32'h0001_0b01, "power cap ro");
    wr(BCR_OFF_LAST, 32'hffff_ffff, 4'hf);
    rd(BCR_OFF_LAST, 32'h0000_0006, "last cap ro");
    wr(8'h84, 32'hffff_ffff, 4'hf);
    rd(8'h84, 32'h0, "unmapped wr");
    @(posedge clock_i);
    hs_in <= 1'b0;
    repeat (3) @(posedge clock_i);
    rd(BCR_OFF_SLOT, 32'h003f_0004, "next off");
    $display("test field access done");
  endtask : t_fields

  task automatic t_power;
    wr(BCR_OFF_PWR_CTL, 32'h3, 4'h1);
    chk("state d3", {30'h0, ps}, 32'h3);
    wr(BCR_OFF_PWR_CTL, 32'h1, 4'hf);
    chk("state d1", {30'h0, ps}, 32'h3);
    wr(BCR_OFF_PWR_CTL, 32'hffff_fffe, 4'hf);
    chk("no reset", {31'h0, crst}, 32'h0);
    rd(BCR_OFF_PWR_CTL, 32'h3, "ctl ro");
    wr(BCR_OFF_PWR_CTL, 32'h0, 4'h2);
    chk("no lane", {30'h0, ps}, 32'h3);
    wr(BCR_OFF_PWR_CTL, 32'h0, 4'h1);
    chk("state d0", {30'h0, ps}, 32'h0);
    chk("reset on", {31'h0, crst}, 32'h1);
    @(posedge clock_i);
    #1;
    chk("reset off", {31'h0, crst}, 32'h0);
    wr(BCR_OFF_PWR_CTL, 32'h0, 4'h1);
    chk("d0 to d0", {31'h0, crst}, 32'h0);
    $display("test power state done");
  endtask : t_power

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  initial begin
    rstn_i = 1'b0;
    req_i  = '0;
    hs_in  = 1'b0;
    repeat (4) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    t_reset();
    t_fields();
    t_power();
    summarize();
  end

  initial begin
    #20000;
    bad_count++;
    summarize();
  end
endmodule : bcr_regs_test
